//--- logic/ecs_defs.svh
// What this block does
// - Edges of the synchronised timer input pin are counted, with software choosing the edge.
// - Software may instead pick the B-timer overflow or another A-timer's overflow as source.
// - The count runs up or down, set by a control bit or by the level on an external pin.
// - On overflow or underflow without free-run, the reload value is loaded and counting goes on.
// - Down counting from n divides by n+1; up counting from n divides by FFF hex minus n plus 1.
// - Counting begins once software writes a one to the count start flag.
// - Counting halts once software writes a zero to the count start flag.
// - Every overflow or underflow sets the wrap status flag, which raises the channel interrupt request only while the mask bit is set.
// - The timer input pin is either a general port or the count source input.
// - The timer output pin is a general port, a pulse output, the direction select input, or switched off.
// - Reading the timer register returns the live counter value.
// - A timer register write while stopped loads both reload register and counter.
// - A timer register write while counting loads only the reload register.
// - With free-run selected no reload happens at a wrap; the count simply carries on.
// - This channel counts single-phase signals only; two-phase counting is not built here.
// - With pulse output enabled the output pin level flips at every counter wrap.
`ifndef ECS_DEFS_SVH
`define ECS_DEFS_SVH

`define ECS_OFF_CTRL        8'h00
`define ECS_OFF_TIMER       8'h04
`define ECS_OFF_STATUS      8'h08
`define ECS_OFF_MASK        8'h0C
`define ECS_OFF_PORT        8'h10

`define ECS_CTRL_START      0
`define ECS_CTRL_FREE       1
`define ECS_CTRL_UP         2
`define ECS_CTRL_DIR_EXT    3
`define ECS_CTRL_IN_COUNT   4
`define ECS_CTRL_EDGE_LSB   5
`define ECS_CTRL_SRC_LSB    7
`define ECS_CTRL_OMODE_LSB  9
`define ECS_CTRL_WMASK      32'h0000_07FF

`define ECS_ST_WRAP         0

`define ECS_PORT_OUT_DATA   0
`define ECS_PORT_OUT_OE     1
`define ECS_PORT_IN_DATA    2
`define ECS_PORT_IN_OE      3
`define ECS_PORT_IN_LEVEL   4
`define ECS_PORT_OUT_LEVEL  5
`define ECS_PORT_WMASK      32'h0000_000F

`define ECS_CTRL_RST        32'h0000_0000
`define ECS_PORT_RST        32'h0000_0000
`define ECS_TIMER_RST       16'h0000
`define ECS_UP_TOP          16'h0FFF
`define ECS_DOWN_WRAP       16'hFFFF

`define ECS_RESP_OKAY       2'h0
`define ECS_RESP_SLVERR     2'h2

`endif

//--- logic/ecs_pkg.sv
package ecs_pkg;

    typedef enum logic [1:0] {
        ECS_EDGE_FALL = 2'h0,
        ECS_EDGE_RISE = 2'h1,
        ECS_EDGE_BOTH = 2'h2,
        ECS_EDGE_ALSO = 2'h3
    } ecs_edge_t;

    typedef enum logic [1:0] {
        ECS_SRC_PIN    = 2'h0,
        ECS_SRC_BTIMER = 2'h1,
        ECS_SRC_ATIMER = 2'h2,
        ECS_SRC_NONE   = 2'h3
    } ecs_src_t;

    typedef enum logic [1:0] {
        ECS_OMODE_PORT  = 2'h0,
        ECS_OMODE_PULSE = 2'h1,
        ECS_OMODE_DIRIN = 2'h2,
        ECS_OMODE_OFF   = 2'h3
    } ecs_omode_t;

endpackage

//--- logic/ecs_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecs_defs.svh"

module ecs_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              timer_input_pin_i,
    output logic                   timer_input_pin_o,
    output logic                   timer_input_pin_oe_o,
    input  wire logic              timer_output_pin_i,
    output logic                   timer_output_pin_o,
    output logic                   timer_output_pin_oe_o,
    input  wire logic              b_timer_channel_two_ovf_i,
    input  wire logic              other_a_timer_channel_ovf_i,
    output logic                   irq_o
);
    import ecs_pkg::*;

    // Refused at elaboration: the decode needs offsets up to 0x10 and
    // the bus address cannot exceed 32 bits
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
        $error("ecs_top: ADDR_W must lie between 5 and 32");
    end

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pin synchronisers; stage one feeds stage two only
    logic in_s1_q, in_s2_q, in_s3_q;
    logic out_s1_q, out_s2_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            in_s1_q  <= 1'b0;
            in_s2_q  <= 1'b0;
            in_s3_q  <= 1'b0;
            out_s1_q <= 1'b0;
            out_s2_q <= 1'b0;
        end else begin
            in_s1_q  <= timer_input_pin_i;
            in_s2_q  <= in_s1_q;
            in_s3_q  <= in_s2_q;
            out_s1_q <= timer_output_pin_i;
            out_s2_q <= out_s1_q;
        end
    end

    // Register bus state
    logic              aw_q, aw_d;
    logic              w_q, w_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              rvalid_q, rvalid_d;
    logic [1:0]        rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d;

    // Block state
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] port_q, port_d;
    logic        st_q, st_d;
    logic        mask_q, mask_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] reload_q, reload_d;
    logic        pulse_q, pulse_d;
    logic        opin_q, opin_d;
    logic        opin_oe_q, opin_oe_d;
    logic        ipin_q, ipin_d;
    logic        ipin_oe_q, ipin_oe_d;

    logic        do_wr;
    logic        wr_hit;
    logic [7:0]  wr_off;
    logic [7:0]  rd_off;
    logic        ar_take;
    logic        rd_hit;
    logic [31:0] rd_val;
    logic [31:0] wr_ctrl;
    logic [31:0] wr_tim;

    assign s_axi_awready_o = !aw_q && !bvalid_q;
    assign s_axi_wready_o  = !w_q && !bvalid_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rresp_o   = rresp_q;
    assign s_axi_rdata_o   = rdata_q;

    assign wr_off = 8'(awaddr_q);
    assign rd_off = 8'(s_axi_araddr_i);
    assign do_wr  = aw_q && w_q && !bvalid_q;
    assign wr_hit = (wr_off == `ECS_OFF_CTRL) || (wr_off == `ECS_OFF_TIMER) ||
                    (wr_off == `ECS_OFF_STATUS) || (wr_off == `ECS_OFF_MASK) ||
                    (wr_off == `ECS_OFF_PORT);
    assign ar_take = s_axi_arvalid_i && !rvalid_q;

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (rd_off)
            `ECS_OFF_CTRL:   rd_val = ctrl_q;
            `ECS_OFF_TIMER:  rd_val = {16'h0000, cnt_q};
            `ECS_OFF_STATUS: rd_val = {31'h0000_0000, st_q};
            `ECS_OFF_MASK:   rd_val = {31'h0000_0000, mask_q};
            `ECS_OFF_PORT: begin
                rd_val = port_q;
                rd_val[`ECS_PORT_IN_LEVEL]  = in_s2_q;
                rd_val[`ECS_PORT_OUT_LEVEL] = out_s2_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        aw_d     = aw_q;
        w_d      = w_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_d     = 1'b1;
            awaddr_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_d     = 1'b1;
            wdata_d = s_axi_wdata_i;
            wstrb_d = s_axi_wstrb_i;
        end
        if (do_wr) begin
            aw_d     = 1'b0;
            w_d      = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = wr_hit ? `ECS_RESP_OKAY : `ECS_RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        if (ar_take) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val;
            rresp_d  = rd_hit ? `ECS_RESP_OKAY : `ECS_RESP_SLVERR;
        end
        if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= `ECS_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= `ECS_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else begin
            aw_q     <= aw_d;
            w_q      <= w_d;
            awaddr_q <= awaddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
        end
    end

    // Counting core
    ecs_edge_t  edge_sel;
    ecs_src_t   src_sel;
    ecs_omode_t omode;
    logic       running;
    logic       up;
    logic       pin_rise;
    logic       pin_fall;
    logic       pin_ev;
    logic       src_ev;
    logic       step;
    logic       wrap;

    assign edge_sel = ecs_edge_t'(ctrl_q[`ECS_CTRL_EDGE_LSB +: 2]);
    assign src_sel  = ecs_src_t'(ctrl_q[`ECS_CTRL_SRC_LSB +: 2]);
    assign omode    = ecs_omode_t'(ctrl_q[`ECS_CTRL_OMODE_LSB +: 2]);
    assign running  = ctrl_q[`ECS_CTRL_START];
    assign pin_rise = in_s2_q && !in_s3_q;
    assign pin_fall = !in_s2_q && in_s3_q;
    assign wr_ctrl  = merge(ctrl_q, wdata_q, wstrb_q) & `ECS_CTRL_WMASK;
    assign wr_tim   = merge({16'h0000, reload_q}, wdata_q, wstrb_q);

    // Direction from the output pin only when it is set up as an input
    always_comb begin
        up = ctrl_q[`ECS_CTRL_UP];
        if (ctrl_q[`ECS_CTRL_DIR_EXT] && omode == ECS_OMODE_DIRIN) begin
            up = out_s2_q;
        end
    end

    always_comb begin
        case (edge_sel)
            ECS_EDGE_FALL: pin_ev = pin_fall;
            ECS_EDGE_RISE: pin_ev = pin_rise;
            default:       pin_ev = pin_rise || pin_fall;
        endcase
        // The pin counts only when it is not used as a general port
        if (!ctrl_q[`ECS_CTRL_IN_COUNT]) begin
            pin_ev = 1'b0;
        end
    end

    always_comb begin
        case (src_sel)
            ECS_SRC_PIN:    src_ev = pin_ev;
            ECS_SRC_BTIMER: src_ev = b_timer_channel_two_ovf_i;
            ECS_SRC_ATIMER: src_ev = other_a_timer_channel_ovf_i;
            default:        src_ev = 1'b0;
        endcase
    end

    // Single-phase counting only; no two-phase decoder in this channel
    assign step = running && src_ev;
    assign wrap = step && (up ? (cnt_q == `ECS_UP_TOP) : (cnt_q == 16'h0000));

    always_comb begin
        ctrl_d    = ctrl_q;
        port_d    = port_q;
        st_d      = st_q;
        mask_d    = mask_q;
        cnt_d     = cnt_q;
        reload_d  = reload_q;
        pulse_d   = pulse_q;
        if (do_wr) begin
            case (wr_off)
                `ECS_OFF_CTRL: ctrl_d = wr_ctrl;
                `ECS_OFF_TIMER: begin
                    reload_d = wr_tim[15:0];
                    if (!running) begin
                        cnt_d = wr_tim[15:0];
                    end
                end
                `ECS_OFF_STATUS: begin
                    if (wstrb_q[0] && wdata_q[`ECS_ST_WRAP]) begin
                        st_d = 1'b0;
                    end
                end
                `ECS_OFF_MASK: begin
                    if (wstrb_q[0]) begin
                        mask_d = wdata_q[0];
                    end
                end
                `ECS_OFF_PORT: port_d = merge(port_q, wdata_q, wstrb_q) & `ECS_PORT_WMASK;
                default: ;
            endcase
        end
        // Counter writes happen only when stopped, so no clash with stepping
        if (step) begin
            if (wrap) begin
                if (ctrl_q[`ECS_CTRL_FREE]) begin
                    cnt_d = up ? cnt_q + 16'h0001 : `ECS_DOWN_WRAP;
                end else begin
                    cnt_d = reload_q;
                end
            end else begin
                cnt_d = up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
            end
        end
        if (wrap) begin
            st_d    = 1'b1;
            pulse_d = !pulse_q;
        end
    end

    // Pin drive is registered so the pads never see decode glitches
    always_comb begin
        ipin_oe_d = !ctrl_q[`ECS_CTRL_IN_COUNT] && port_q[`ECS_PORT_IN_OE];
        ipin_d    = port_q[`ECS_PORT_IN_DATA];
        case (omode)
            ECS_OMODE_PORT: begin
                opin_oe_d = port_q[`ECS_PORT_OUT_OE];
                opin_d    = port_q[`ECS_PORT_OUT_DATA];
            end
            ECS_OMODE_PULSE: begin
                opin_oe_d = 1'b1;
                opin_d    = pulse_d;
            end
            default: begin
                opin_oe_d = 1'b0;
                opin_d    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_q    <= `ECS_CTRL_RST;
            port_q    <= `ECS_PORT_RST;
            st_q      <= 1'b0;
            mask_q    <= 1'b0;
            cnt_q     <= `ECS_TIMER_RST;
            reload_q  <= `ECS_TIMER_RST;
            pulse_q   <= 1'b0;
            opin_q    <= 1'b0;
            opin_oe_q <= 1'b0;
            ipin_q    <= 1'b0;
            ipin_oe_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            port_q    <= port_d;
            st_q      <= st_d;
            mask_q    <= mask_d;
            cnt_q     <= cnt_d;
            reload_q  <= reload_d;
            pulse_q   <= pulse_d;
            opin_q    <= opin_d;
            opin_oe_q <= opin_oe_d;
            ipin_q    <= ipin_d;
            ipin_oe_q <= ipin_oe_d;
        end
    end

    assign timer_input_pin_o     = ipin_q;
    assign timer_input_pin_oe_o  = ipin_oe_q;
    assign timer_output_pin_o    = opin_q;
    assign timer_output_pin_oe_o = opin_oe_q;
    assign irq_o                 = st_q && mask_q;

endmodule // ecs_top

`default_nettype wire

//--- verification/ecs_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ecs_top_asserts (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence wr_resp;
        !s_axi_bvalid_o ##1 s_axi_bvalid_o;
    endsequence
    a_write_answer: assert property (wr_take |=> wr_resp)
        else $error("write response not two cycles after take");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data not one cycle after take");
    a_b_single: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write response repeated");
    a_r_single: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read data repeated");
    a_ready_gap: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write ready during response");
    a_ar_gate: assert property (s_axi_arready_o == !s_axi_rvalid_o)
        else $error("read ready not inverse of read valid");
    a_irq_sticky: assert property ($fell(irq_o) |-> $rose(s_axi_bvalid_o))
        else $error("interrupt dropped without a register write");
    a_resp_code: assert property (s_axi_bvalid_o |-> s_axi_bresp_o inside {2'h0, 2'h2})
        else $error("write response code illegal");
endmodule // ecs_top_asserts
bind ecs_top ecs_top_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o));
`default_nettype wire

//--- verification/ecs_evt_src.sv
`timescale 1ns/10ps
`default_nettype none
module ecs_evt_src (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       go_i,
    input  wire logic [7:0] cnt_i,
    output logic            pin_o,
    output logic            busy_o
);
    logic [7:0] left_q;
    logic [2:0] ph_q;
    // Whole pulses only: four cycles high after four low, so every pulse has both edges
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            left_q <= 8'h00;
            ph_q   <= 3'h0;
        end else if (go_i) begin
            left_q <= cnt_i;
            ph_q   <= 3'h0;
        end else if (left_q != 8'h00) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h7) left_q <= left_q - 8'h01;
        end
    end
    assign pin_o  = (left_q != 8'h00) && ph_q[2];
    assign busy_o = go_i || (left_q != 8'h00);
endmodule // ecs_evt_src
`default_nettype wire

//--- verification/ecs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecs_defs.svh"
module ecs_top_tb;
    import ecs_pkg::*;
    logic        clk_i = 0, resetn_i = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        bovf = 0, aovf = 0, dirpin = 0, go = 0;
    logic [7:0]  awaddr = 0, araddr = 0, npulse = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic        awready, wready, bvalid, arready, rvalid, irq, src_pin, busy;
    logic        ipo, ipoe, opo, opoe;
    logic [15:0] seed = 16'h0016, n;
    int          miscompares = 0, checks = 0, cyc = 0;
    // Wire levels from every driver's enable; the partner idles low
    wire inpin  = ipoe ? ipo : src_pin;
    wire outpin = opoe ? opo : dirpin;

    always #25 clk_i = ~clk_i;

    ecs_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(1'b1), .timer_input_pin_i(inpin), .timer_input_pin_o(ipo),
        .timer_input_pin_oe_o(ipoe), .timer_output_pin_i(outpin), .timer_output_pin_o(opo),
        .timer_output_pin_oe_o(opoe), .b_timer_channel_two_ovf_i(bovf),
        .other_a_timer_channel_ovf_i(aovf), .irq_o(irq));
    ecs_evt_src u_src (.clk_i(clk_i), .resetn_i(resetn_i), .go_i(go), .cnt_i(npulse),
        .pin_o(src_pin), .busy_o(busy));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        rs = bresp;
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a; arvalid <= 1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rd = rdata; rs = rresp;
    endtask
    task automatic chkrd(input string nm, input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(nm, e, rd);
    endtask
    // Pin sync and edge detect need three edges; four more cycles give margin
    task automatic pulses(input logic [7:0] k);
        go <= 1; npulse <= k;
        @(posedge clk_i);
        go <= 0;
        do @(posedge clk_i); while (busy);
        repeat (4) @(posedge clk_i);
    endtask
    task automatic ovf(input bit sel, input int k);
        repeat (k) begin
            bovf <= !sel; aovf <= sel;
            @(posedge clk_i);
            bovf <= 0; aovf <= 0;
            @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1;
        for (int i = 0; i < 5; i++) chkrd("reset value", 8'(i * 4), 32'h0);
        wr(8'h14, 32'h1); chk("unmapped bresp", `ECS_RESP_SLVERR, rs);
        chkrd("unmapped rdata", 8'h14, 32'h0); chk("unmapped rresp", `ECS_RESP_SLVERR, rs);
        wr(`ECS_OFF_TIMER, 32'hABCD_1234);
        chk("timer bresp", `ECS_RESP_OKAY, rs);
        chkrd("timer width", `ECS_OFF_TIMER, 32'h1234);
        chk("timer rresp", `ECS_RESP_OKAY, rs);
        $display("test registers done");
        // The driven level needs two more edges through the pin synchroniser
        wr(`ECS_OFF_PORT, 32'hC); repeat (3) @(posedge clk_i);
        chk("inpin drive", 32'h3, {ipoe, ipo});
        chkrd("port level", `ECS_OFF_PORT, 32'h1C);
        wr(`ECS_OFF_PORT, 32'h0);
        for (int e = 0; e < 4; e++) begin
            wr(`ECS_OFF_CTRL, 0); wr(`ECS_OFF_TIMER, 32'h100);
            wr(`ECS_OFF_CTRL, 32'h11 | (e << 5)); pulses(1);
            chkrd("edge select", `ECS_OFF_TIMER, e >= 2 ? 32'hFE : 32'hFF);
        end
        $display("test pin edges done");
        seed = lfsr(seed); n = {13'h0, seed[2:0]} + 16'h1;
        wr(`ECS_OFF_CTRL, 0); wr(`ECS_OFF_TIMER, n); wr(`ECS_OFF_MASK, 1);
        wr(`ECS_OFF_STATUS, 1); wr(`ECS_OFF_CTRL, 32'h231);
        pulses(n[7:0]); chkrd("down before wrap", `ECS_OFF_TIMER, 0);
        chk("irq before wrap", 0, irq);
        pulses(1); chkrd("down reload", `ECS_OFF_TIMER, n);
        chk("irq at wrap", 1, irq);
        chk("pulse toggle", 1, opo);
        wr(`ECS_OFF_MASK, 0); chk("irq masked", 0, irq);
        wr(`ECS_OFF_MASK, 1); chk("irq unmasked", 1, irq);
        pulses(1); wr(`ECS_OFF_TIMER, 32'h20);
        chkrd("running write", `ECS_OFF_TIMER, n - 1);
        wr(`ECS_OFF_CTRL, 32'h30); pulses(2);
        chkrd("stopped hold", `ECS_OFF_TIMER, n - 1);
        wr(`ECS_OFF_STATUS, 1); chk("irq cleared", 0, irq);
        $display("test down count done");
        seed = lfsr(seed); n = {13'h0, seed[2:0]};
        wr(`ECS_OFF_TIMER, 32'hFFF - n); wr(`ECS_OFF_CTRL, 32'h85);
        ovf(0, n); chkrd("up top", `ECS_OFF_TIMER, 32'hFFF);
        chkrd("no wrap yet", `ECS_OFF_STATUS, 0);
        ovf(0, 1); chkrd("up reload", `ECS_OFF_TIMER, 32'hFFF - n);
        chkrd("up wrap flag", `ECS_OFF_STATUS, 1);
        $display("test up count done");
        wr(`ECS_OFF_CTRL, 0); wr(`ECS_OFF_TIMER, 1); wr(`ECS_OFF_CTRL, 32'h103);
        ovf(1, 2); chkrd("free run", `ECS_OFF_TIMER, 32'hFFFF);
        wr(`ECS_OFF_CTRL, 32'h781); ovf(0, 2);
        chkrd("no source", `ECS_OFF_TIMER, 32'hFFFF);
        chk("output off", 0, {opoe, opo});
        $display("test free run done");
        wr(`ECS_OFF_CTRL, 0); wr(`ECS_OFF_TIMER, 5); dirpin <= 1;
        wr(`ECS_OFF_CTRL, 32'h509); ovf(1, 2);
        chkrd("pin dir up", `ECS_OFF_TIMER, 7);
        dirpin <= 0; repeat (3) @(posedge clk_i); ovf(1, 1);
        chkrd("pin dir down", `ECS_OFF_TIMER, 6);
        $display("test direction pin done");
        report_and_stop();
    end
endmodule // ecs_top_tb
`default_nettype wire
